// ==== bench/dsl_led.sv ====
// External lamp and pull-up resistor on the open-drain status pin.
`timescale 1ns/1ps
`default_nettype none
module dsl_led (
  input wire logic drive_val,
  input wire logic drive_en,
  output logic pin_level,
  output logic lit
);
  // The resistor pulls a released pin high; the lamp lights only when pulled low.
  tri1 pin;
  assign pin = drive_en ? drive_val : 1'bz;
  assign pin_level = pin;
  assign lit = (pin === 1'b0);
endmodule
`default_nettype wire

// ==== bench/testbench.sv ====
// Self-checking bench for the status lamp controller.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import dsl_pkg::*;
  logic mclk = 0, sys_rst = 1, cmd = 0, fmt = 0, cyl = 0, sel = 0;
  dsl_spin_type spin = DSL_SPUN_DOWN;
  dsl_spin_type s;
  logic lamp_out, lamp_oe, pin_level, lit;
  logic [2:0] r;
  logic q[$];
  int errors = 0, tests_run = 0;
  // Free-running system clock.
  always #10 mclk = ~mclk;
  dsl_lamp i_dut (.mclk(mclk), .sys_rst(sys_rst), .spin_state(spin), .cmd_active(cmd),
    .format_active(fmt), .cyl_change(cyl), .lamp_meaning_select(sel),
    .status_lamp_in(pin_level), .status_lamp_out(lamp_out), .status_lamp_oe(lamp_oe));
  dsl_led i_led (.drive_val(lamp_out), .drive_en(lamp_oe), .pin_level(pin_level), .lit(lit));
  // Compares one lamp reading against its note.
  task automatic check(input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("BAD %0t exp %h got %h", $time, e, g);
    end
  endtask
  // Prints the verdict and stops.
  task automatic results;
    if (errors == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Drives one input set and notes the lamp expected one edge later.
  task automatic apply(input dsl_spin_type t, input logic c, input logic f, input logic m,
    input logic e);
    @(negedge mclk);
    spin = t;
    cmd = c;
    fmt = f;
    sel = m;
    @(posedge mclk);
    q.push_back(e);
  endtask
  // Sends one cylinder change pulse and notes the lamp after it settles.
  task automatic pulse(input logic e);
    @(negedge mclk);
    cyl = 1;
    @(negedge mclk);
    cyl = 0;
    repeat (2) @(posedge mclk);
    q.push_back(e);
  endtask
  // Takes the oldest note whenever a settled reading is due.
  always @(negedge mclk) begin
    if (q.size() > 0) check(q.pop_front(), lit);
  end
  // Cuts a hung run short.
  initial begin
    #100000;
    errors++;
    results;
  end
  // ****************************************
  // Stimulus
  // ****************************************
  initial begin
    void'($urandom(32'h4590_60a6));
    repeat (3) @(negedge mclk);
    sys_rst = 0;
    check(1'b0, lit);
    for (int i = 0; i < 24; i++) begin
      r = 3'($urandom);
      s = r[0] ? DSL_SPUN_UP : DSL_SPUN_DOWN;
      apply(s, r[1], 0, r[2], (s == DSL_SPUN_UP) ? ~(r[1] ^ r[2]) : r[1]);
    end
    apply(DSL_SPUN_UP, 0, 0, 1, 0);
    repeat (4) apply(DSL_SPINNING_UP, 0, 0, 1, 1);
    apply(DSL_SPINNING_DOWN, 0, 0, 1, 1);
    apply(DSL_SPUN_UP, 0, 0, 1, 0);
    apply(DSL_SPINNING_DOWN, 0, 0, 1, 1);
    apply(DSL_SPUN_UP, 0, 0, 0, 1);
    apply(DSL_SPUN_UP, 0, 1, 0, 1);
    pulse(0);
    apply(DSL_SPUN_UP, 1, 1, 1, 0);
    pulse(1);
    apply(DSL_SPUN_UP, 0, 0, 1, 0);
    pulse(0);
    apply(DSL_SPINNING_UP, 0, 1, 1, 1);
    repeat (2) @(negedge mclk);
    results;
  end
endmodule
`default_nettype wire

// ==== hw/dsl_blink.sv ====
// Half-second blink phase generator for spin transitions.
`timescale 1ns/1ps
`default_nettype none
module dsl_blink (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic restart,
  input wire logic run,
  output logic phase
);
  import dsl_pkg::*;

  logic [24:0] count;
  wire at_last = (count == BLINK_LAST);

  // Counts half periods and flips the phase; restart begins lit.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      count <= 25'h000_0000;
      phase <= 1'b0;
    end else if (restart) begin
      count <= 25'h000_0000;
      phase <= 1'b1;
    end else if (run) begin
      count <= at_last ? 25'h000_0000 : count + 25'h000_0001;
      if (at_last) begin
        phase <= ~phase;
      end
    end
  end

  // Assertion: outside a restart, phase only flips after a full half period of counting.
  property p_blink_hold;
    @(posedge mclk) disable iff (sys_rst)
      (run && !restart && !at_last) |=> $stable(phase);
  endproperty
  a_blink_hold: assert property (p_blink_hold) else $error("blink phase moved early");

endmodule
`default_nettype wire

// ==== hw/dsl_lamp.sv ====
// Top level of the drive status lamp controller.
`timescale 1ns/1ps
`default_nettype none
module dsl_lamp (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire dsl_pkg::dsl_spin_type spin_state,
  input wire logic cmd_active,
  input wire logic format_active,
  input wire logic cyl_change,
  input wire logic lamp_meaning_select,
  input wire logic status_lamp_in,
  output logic status_lamp_out,
  output logic status_lamp_oe
);
  import dsl_pkg::*;

  // ****************************************
  // Decoding
  // ****************************************
  logic lamp_on;
  logic blink_phase;
  logic fmt_lamp;
  dsl_spin_type last_spin;

  // Spin transition detection.
  wire in_transition = (spin_state == DSL_SPINNING_UP) || (spin_state == DSL_SPINNING_DOWN);
  wire trans_start = in_transition && (last_spin != spin_state);
  wire spun_up = (spin_state == DSL_SPUN_UP);
  // Activity meaning: down follows activity, up follows activity xor not select.
  wire act_lamp = spun_up ? (cmd_active ~^ lamp_meaning_select)
                          : cmd_active;
  // Blink first, then format toggle, then activity; a fresh transition lights at once.
  wire next_lamp_on = in_transition ? (trans_start | blink_phase)
                    : format_active ? fmt_lamp : act_lamp;

  dsl_blink u_blink (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .restart(trans_start),
    .run(in_transition),
    .phase(blink_phase)
  );

  // Format toggle: loads the present lamp at format start, flips per cylinder.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      fmt_lamp <= 1'b0;
    end else if (!format_active) begin
      fmt_lamp <= next_lamp_on; // Tracks the lamp so format starts from its present state.
    end else if (cyl_change) begin
      fmt_lamp <= ~fmt_lamp;
    end
  end

  // Registered lamp state and open-drain pin drive.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      last_spin <= DSL_SPUN_DOWN;
      lamp_on <= 1'b0;
      status_lamp_out <= 1'b0;
      status_lamp_oe <= 1'b0;
    end else begin
      last_spin <= spin_state;
      lamp_on <= next_lamp_on;
      status_lamp_out <= 1'b0;
      status_lamp_oe <= next_lamp_on;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  property p_down_idle;
    @(posedge mclk) disable iff (sys_rst)
      (spin_state == DSL_SPUN_DOWN && !cmd_active && !format_active) |=> !status_lamp_oe;
  endproperty
  a_down_idle: assert property (p_down_idle) else $error("lamp lit while down and idle");

  property p_down_busy;
    @(posedge mclk) disable iff (sys_rst)
      (spin_state == DSL_SPUN_DOWN && cmd_active && !format_active) |=> status_lamp_oe;
  endproperty
  a_down_busy: assert property (p_down_busy) else $error("lamp dark while down and busy");

  property p_up_idle;
    @(posedge mclk) disable iff (sys_rst)
      (spun_up && !cmd_active && !format_active) |=> (status_lamp_oe == !$past(lamp_meaning_select));
  endproperty
  a_up_idle: assert property (p_up_idle) else $error("wrong lamp when up and idle");

  property p_up_busy;
    @(posedge mclk) disable iff (sys_rst)
      (spun_up && cmd_active && !format_active) |=> (status_lamp_oe == $past(lamp_meaning_select));
  endproperty
  a_up_busy: assert property (p_up_busy) else $error("wrong lamp when up and busy");

  property p_trans_lit;
    @(posedge mclk) disable iff (sys_rst)
      trans_start |=> status_lamp_oe;
  endproperty
  a_trans_lit: assert property (p_trans_lit) else $error("blink did not restart lit");

  property p_fmt_toggle;
    @(posedge mclk) disable iff (sys_rst)
      (format_active && !in_transition && cyl_change) ##1 (format_active && !in_transition)
        |=> (status_lamp_oe != $past(status_lamp_oe));
  endproperty
  a_fmt_toggle: assert property (p_fmt_toggle) else $error("format toggle missed");

  property p_never_high;
    @(posedge mclk) disable iff (sys_rst)
      status_lamp_oe |-> !status_lamp_out;
  endproperty
  a_never_high: assert property (p_never_high) else $error("lamp pin driven high");

  property p_trans_blink;
    @(posedge mclk) disable iff (sys_rst)
      (in_transition && !trans_start) |=> (status_lamp_oe == $past(blink_phase));
  endproperty
  a_trans_blink: assert property (p_trans_blink) else $error("lamp not following blink");

endmodule
`default_nettype wire

// ==== hw/dsl_pkg.sv ====
// Constants and types for the drive status lamp controller.
package dsl_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_FREQ_HZ = 50000000;
  localparam int BLINK_HALF_MS = 500;
  localparam int BLINK_HALF_CYCLES = CLK_FREQ_HZ / 1000 * BLINK_HALF_MS;
  localparam int BLINK_CNT_W = 25;
  localparam logic [24:0] BLINK_LAST = 25'(BLINK_HALF_CYCLES - 1);

  // ****************************************
  // Spindle state encoding
  // ****************************************
  typedef enum logic [1:0] {
    DSL_SPUN_DOWN = 2'h0,
    DSL_SPINNING_UP = 2'h1,
    DSL_SPUN_UP = 2'h3,
    DSL_SPINNING_DOWN = 2'h2
  } dsl_spin_type;

  // Mode page that holds the meaning select bit.
  localparam logic [7:0] MEANING_PAGE_CODE = 8'h19;

endpackage
